/* core/orp_pkg.sv */
// Constants and types for the remappable output pin selector block.
package orp_pkg;
  localparam int NUM_PINS = 14;
  localparam int NUM_REGS = 7;
  localparam int FIRST_PIN = 6;
  localparam int SEL_W = 6;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int NUM_FUNCS = 64;
  localparam int ODD_LSB = 8;
  localparam int EVEN_LSB = 0;
  localparam int SMALL_PKG_PIN_IDX = 15 - FIRST_PIN;
  localparam logic [5:0] SEL_RST = 6'h00;
  localparam logic [5:0] SEL_NONE = 6'h00;
  // Highest function number that has a peripheral behind it
  localparam logic [5:0] FUNC_LAST = 6'h1f;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [1:0] PAD_ZERO = 2'h0;
  localparam logic OUT_RST = 1'b0;
  localparam logic [3:0] OFS_PINS_6_7 = 4'h0;
  localparam logic [3:0] OFS_PINS_8_9 = 4'h1;
  localparam logic [3:0] OFS_PINS_10_11 = 4'h2;
  localparam logic [3:0] OFS_PINS_12_13 = 4'h3;
  localparam logic [3:0] OFS_PINS_14_15 = 4'h4;
  localparam logic [3:0] OFS_PINS_16_17 = 4'h5;
  localparam logic [3:0] OFS_PINS_18_19 = 4'h6;
  localparam logic [3:0] REG_OFS [NUM_REGS] = '{OFS_PINS_6_7, OFS_PINS_8_9, OFS_PINS_10_11,
                                               OFS_PINS_12_13, OFS_PINS_14_15, OFS_PINS_16_17,
                                               OFS_PINS_18_19};
  typedef logic [5:0] orp_sel_t;
endpackage : orp_pkg

/* core/orp_sel_if.sv */
// Interface carrying the per-pin selector fields from the register file to the pin mux.
`timescale 1ns/1ps
interface orp_sel_if;
  orp_pkg::orp_sel_t sel [orp_pkg::NUM_PINS];
  modport regs (output sel);
  modport mux (input sel);
endinterface : orp_sel_if

/* core/orp_pin_mux.sv */
// Per-pin selection of a peripheral output onto each remappable pad.
`timescale 1ns/1ps
module orp_pin_mux (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset, active high
  orp_sel_if.mux sel_if, // Selector fields
  input wire logic [orp_pkg::NUM_FUNCS-1:0] periph_out, // Peripheral outputs by function number
  output logic [orp_pkg::NUM_PINS-1:0] pad_out, // Pad data
  output logic [orp_pkg::NUM_PINS-1:0] pad_remap_en // High while a peripheral owns the pad
);

  // True when the selector names a peripheral that exists
  function automatic logic func_valid(input orp_pkg::orp_sel_t s);
    func_valid = (s != orp_pkg::SEL_NONE) && (s <= orp_pkg::FUNC_LAST);
  endfunction : func_valid

  genvar g;
  generate
    for (g = 0; g < orp_pkg::NUM_PINS; g++) begin : g_pin
      wire logic sel_ok;
      wire logic sel_bit;
      assign sel_ok = func_valid(sel_if.sel[g]);
      assign sel_bit = sel_ok ? periph_out[sel_if.sel[g]] : orp_pkg::OUT_RST;
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          pad_out[g] <= orp_pkg::OUT_RST;
          pad_remap_en[g] <= orp_pkg::OUT_RST;
        end else begin
          pad_out[g] <= sel_bit;
          pad_remap_en[g] <= sel_ok;
        end
      end
    end
  endgenerate

endmodule : orp_pin_mux

/* core/orp_regs_top.sv */
// Register file and top level of the remappable output pin selector for pins 6 to 19.
`timescale 1ns/1ps
module orp_regs_top (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic [orp_pkg::ADDR_W-1:0] reg_addr, // Register index
  input wire logic [orp_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [orp_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after the strobe
  input wire logic small_pkg_pin, // Strap: smallest package variant
  input wire logic [orp_pkg::NUM_FUNCS-1:0] periph_out, // Peripheral outputs by function number
  output logic [orp_pkg::NUM_PINS-1:0] pad_out, // Pad data for pins 6..19
  output logic [orp_pkg::NUM_PINS-1:0] pad_remap_en // High while a peripheral owns the pad
);

  orp_sel_if sel_if ();

  logic small_meta_r;
  logic small_r;
  orp_pkg::orp_sel_t fld_r [orp_pkg::NUM_PINS];

  // Named views of the fields, in the order software sees them
  orp_pkg::orp_sel_t pin6_out_select;
  orp_pkg::orp_sel_t pin7_out_select;
  orp_pkg::orp_sel_t pin8_out_select;
  orp_pkg::orp_sel_t pin9_out_select;
  orp_pkg::orp_sel_t pin10_out_select;
  orp_pkg::orp_sel_t pin11_out_select;
  orp_pkg::orp_sel_t pin12_out_select;
  orp_pkg::orp_sel_t pin13_out_select;
  orp_pkg::orp_sel_t pin14_out_select;
  orp_pkg::orp_sel_t pin15_out_select;
  orp_pkg::orp_sel_t pin16_out_select;
  orp_pkg::orp_sel_t pin17_out_select;
  orp_pkg::orp_sel_t pin18_out_select;
  orp_pkg::orp_sel_t pin19_out_select;

  logic [orp_pkg::DATA_W-1:0] output_map_pins_6_7;
  logic [orp_pkg::DATA_W-1:0] output_map_pins_8_9;
  logic [orp_pkg::DATA_W-1:0] output_map_pins_10_11;
  logic [orp_pkg::DATA_W-1:0] output_map_pins_12_13;
  logic [orp_pkg::DATA_W-1:0] output_map_pins_14_15;
  logic [orp_pkg::DATA_W-1:0] output_map_pins_16_17;
  logic [orp_pkg::DATA_W-1:0] output_map_pins_18_19;

  logic [orp_pkg::NUM_REGS-1:0] reg_hit;
  logic [orp_pkg::NUM_REGS-1:0] reg_wr_hit;
  logic [orp_pkg::DATA_W-1:0] rd_sel;
  logic [orp_pkg::DATA_W-1:0] reg_rdata_nxt;

  // True when the bus index names the register at this offset
  function automatic logic idx_match(
    input logic [orp_pkg::ADDR_W-1:0] idx,
    input logic [orp_pkg::ADDR_W-1:0] ofs
  );
    idx_match = (idx == ofs);
  endfunction : idx_match

  // Register word of one pin pair; spare bits are always zero
  function automatic logic [orp_pkg::DATA_W-1:0] pack_pair(
    input orp_pkg::orp_sel_t odd_sel,
    input orp_pkg::orp_sel_t even_sel
  );
    pack_pair = {orp_pkg::PAD_ZERO, odd_sel, orp_pkg::PAD_ZERO, even_sel};
  endfunction : pack_pair

  // Selector field of one pin out of a write word
  function automatic orp_pkg::orp_sel_t field_of(
    input logic [orp_pkg::DATA_W-1:0] word,
    input bit odd
  );
    field_of = odd ? word[orp_pkg::ODD_LSB +: orp_pkg::SEL_W] : word[orp_pkg::EVEN_LSB +: orp_pkg::SEL_W];
  endfunction : field_of

  // Strap passes two flops before use
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      small_meta_r <= 1'b0;
      small_r <= 1'b0;
    end else begin
      small_meta_r <= small_pkg_pin;
      small_r <= small_meta_r;
    end
  end

  genvar r;
  generate
    for (r = 0; r < orp_pkg::NUM_REGS; r++) begin : g_reg
      assign reg_hit[r] = idx_match(reg_addr, orp_pkg::REG_OFS[r]);
      assign reg_wr_hit[r] = reg_wr && reg_hit[r];
    end
  endgenerate

  genvar p;
  generate
    for (p = 0; p < orp_pkg::NUM_PINS; p++) begin : g_fld
      localparam bit IS_ODD = (p % 2 == 1);
      localparam bit CAN_DROP = (p == orp_pkg::SMALL_PKG_PIN_IDX);
      wire logic wr_hit;
      wire logic dropped;
      wire orp_pkg::orp_sel_t fld_nxt;
      assign wr_hit = reg_wr_hit[p/2];
      assign dropped = CAN_DROP && small_r;
      assign fld_nxt = dropped ? orp_pkg::SEL_RST : (wr_hit ? field_of(reg_wdata, IS_ODD) : fld_r[p]);
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          fld_r[p] <= orp_pkg::SEL_RST;
        end else begin
          fld_r[p] <= fld_nxt;
        end
      end
      assign sel_if.sel[p] = fld_r[p];
    end
  endgenerate

  assign pin6_out_select = fld_r[0];
  assign pin7_out_select = fld_r[1];
  assign pin8_out_select = fld_r[2];
  assign pin9_out_select = fld_r[3];
  assign pin10_out_select = fld_r[4];
  assign pin11_out_select = fld_r[5];
  assign pin12_out_select = fld_r[6];
  assign pin13_out_select = fld_r[7];
  assign pin14_out_select = fld_r[8];
  assign pin15_out_select = fld_r[9];
  assign pin16_out_select = fld_r[10];
  assign pin17_out_select = fld_r[11];
  assign pin18_out_select = fld_r[12];
  assign pin19_out_select = fld_r[13];

  assign output_map_pins_6_7 = pack_pair(pin7_out_select, pin6_out_select);
  assign output_map_pins_8_9 = pack_pair(pin9_out_select, pin8_out_select);
  assign output_map_pins_10_11 = pack_pair(pin11_out_select, pin10_out_select);
  assign output_map_pins_12_13 = pack_pair(pin13_out_select, pin12_out_select);
  assign output_map_pins_14_15 = pack_pair(pin15_out_select, pin14_out_select);
  assign output_map_pins_16_17 = pack_pair(pin17_out_select, pin16_out_select);
  assign output_map_pins_18_19 = pack_pair(pin19_out_select, pin18_out_select);

  // Unmapped index reads zero
  assign rd_sel = reg_hit[0] ? output_map_pins_6_7 :
                  reg_hit[1] ? output_map_pins_8_9 :
                  reg_hit[2] ? output_map_pins_10_11 :
                  reg_hit[3] ? output_map_pins_12_13 :
                  reg_hit[4] ? output_map_pins_14_15 :
                  reg_hit[5] ? output_map_pins_16_17 :
                  reg_hit[6] ? output_map_pins_18_19 :
                  orp_pkg::RDATA_RST;

  assign reg_rdata_nxt = reg_rd ? rd_sel : orp_pkg::RDATA_RST;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= orp_pkg::RDATA_RST;
    end else begin
      reg_rdata <= reg_rdata_nxt;
    end
  end

  orp_pin_mux u_mux (
    .clk_sys(clk_sys),
    .srst(srst),
    .sel_if(sel_if.mux),
    .periph_out(periph_out),
    .pad_out(pad_out),
    .pad_remap_en(pad_remap_en)
  );

endmodule : orp_regs_top

/* verif/orp_regs_props.sv */
// Port checker for the remappable output pin selector
`timescale 1ns/1ps
module orp_regs_props (
  input wire logic clk_sys, // Clock
  input wire logic srst, // Reset
  input wire logic [3:0] reg_addr, // Index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic small_pkg_pin, // Strap
  input wire logic [63:0] periph_out, // Functions
  input wire logic [13:0] pad_out, // Pads
  input wire logic [13:0] pad_remap_en // Owned pads
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_wr_rd; reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0; endsequence
  property p_hi; reg_rdata[15:14] == 2'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper spare bits set");
  property p_lo; reg_rdata[7:6] == 2'h0; endproperty
  a_lo: assert property (p_lo) else $error("middle spare bits set");
  property p_wr_rd; s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & 16'h3f3f); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback wrong");
  property p_unmap; reg_rd && reg_addr > 4'h6 |=> reg_rdata == 16'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_en; (pad_out & ~pad_remap_en) == 14'h0; endproperty
  a_en: assert property (p_en) else $error("unowned pad driven");
  property p_rst; $past(srst) |-> pad_remap_en == 14'h0 && pad_out == 14'h0; endproperty
  a_rst: assert property (p_rst) else $error("pads not clear after reset");
  property p_po0; $past(periph_out) == 64'h0 |-> pad_out == 14'h0; endproperty
  a_po0: assert property (p_po0) else $error("pad high with no source");
  property p_small; small_pkg_pin [*6] |-> !pad_remap_en[9]; endproperty
  a_small: assert property (p_small) else $error("pin 15 owned in small package");
  sequence s_strap_high; small_pkg_pin [*4]; endsequence
  property p_small_rd; s_strap_high ##0 (reg_rd && reg_addr == 4'h4) |=> reg_rdata[13:8] == 6'h0; endproperty
  a_small_rd: assert property (p_small_rd) else $error("pin 15 field reads nonzero in small package");
  property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
endmodule : orp_regs_props
bind orp_regs_top orp_regs_props orp_regs_props_i (.*);

/* verif/orp_regs_top_tb_top.sv */
// Self-checking bench for the remappable output pin selector
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("unexpected %0t: mismatch %h vs %h", $time, a, b); end end
module orp_regs_top_tb_top;
  logic clk_sys = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, small_pkg_pin = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, q;
  logic [63:0] periph_out = 64'h0;
  logic [13:0] pad_out, pad_remap_en;
  int n_fail = 0, tests_run = 0;
  // Index, write value, expected readback
  logic [35:0] rows [6] = '{{4'h0, 16'hffff, 16'h3f3f}, {4'h1, 16'h2a15, 16'h2a15}, {4'h3, 16'hc0c0, 16'h0000},
                            {4'h4, 16'h0101, 16'h0101}, {4'h6, 16'h1f20, 16'h1f20}, {4'h9, 16'h1234, 16'h0000}};
  orp_regs_top orp_regs_top_i (.*);
  always #50 clk_sys = ~clk_sys;
  // A write is followed at once by a read of the same index
  task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (w) begin
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      reg_rd <= 1'h1;
    end
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 q = reg_rdata;
  endtask : bus
  task stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    #1000000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'h0;
    bus(1'h0, 4'h0, 16'h0);
    `CHK(q, 16'h0000)
    `CHK(pad_remap_en, 14'h0)
    for (int i = 0; i < 6; i++) begin
      bus(1'h1, rows[i][35:32], rows[i][31:16]);
      `CHK(q, rows[i][15:0])
    end
    `CHK(pad_remap_en, 14'h2304)
    $display("register rows done");
    @(posedge clk_sys);
    periph_out <= 64'h0000_0000_8000_0020;
    bus(1'h1, 4'h0, 16'h2005);
    `CHK(pad_out[1:0], 2'h1)
    `CHK(pad_remap_en[1:0], 2'h1)
    `CHK(pad_out, 14'h2001)
    @(posedge clk_sys);
    periph_out <= 64'h0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK(pad_out, 14'h0)
    $display("pad routing done");
    @(posedge clk_sys);
    small_pkg_pin <= 1'h1;
    repeat (8) @(posedge clk_sys);
    bus(1'h1, 4'h4, 16'h0101);
    `CHK(q, 16'h0001)
    `CHK(pad_remap_en[9], 1'h0)
    @(posedge clk_sys);
    srst <= 1'h1;
    @(posedge clk_sys);
    srst <= 1'h0;
    bus(1'h0, 4'h1, 16'h0);
    `CHK(q, 16'h0000)
    $display("strap and reset done");
    stop_test();
  end
endmodule : orp_regs_top_tb_top
